// [core/terminal_ctl_defs.vh]
`ifndef TERMINAL_CTL_DEFS_VH
`define TERMINAL_CTL_DEFS_VH

// register byte offsets
`define OFS_SELECT 8'h00
`define OFS_TX_DATA 8'h04
`define OFS_RX_DATA 8'h08
`define OFS_STATUS 8'h0C
`define OFS_ECHO 8'h10
`define OFS_MOTOR 8'h14
`define OFS_BLOCK_ACK 8'h18
`define OFS_SENSE7 8'h40
`define OFS_SENSE0_4 8'h60

// select function codes, device 7
`define SEL_AUTO_ECHO 3'h0
`define SEL_KEYBOARD 3'h1
`define SEL_STEP_READ 3'h2
`define SEL_CONT_READ 3'h3
`define SEL_INIT 3'h4
`define SEL_WORD_MASK 3'h5
`define SEL_BLOCK_MASK 3'h6
`define SEL_MASK_OFF 3'h7

// sense function codes, device 7
`define SNS_READY 3'h1
`define SNS_WORD_MASK 3'h2
`define SNS_NOT_BUSY 3'h3
`define SNS_CTS 3'h4
`define SNS_MOTOR 3'h5
`define SNS_PARITY 3'h6
`define SNS_FULL_DUPLEX 3'h7

// interrupt vectors and jumper relocation
`define WORD_VECTOR 16'h0002
`define BLOCK_VECTOR 16'h0006
`define VECTOR_RELOCATE 16'h0020
`define VECTOR_OFFSET 16'h0100

// reset values
`define MOTOR_RESET 1'b1
`define READ_MODE_RESET 1'b0

// timing
`define CLK_HZ 200000000
`define MOTOR_DELAY_MS 600
`define BAUD_RATE 110
`define MOTOR_DELAY_CYCLES (`CLK_HZ / 1000 * `MOTOR_DELAY_MS)
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)

`endif

// [core/terminal_ctl.v]
`timescale 1ns/1ps
`include "terminal_ctl_defs.vh"

module terminal_ctl #(
  parameter MOTOR_DELAY = `MOTOR_DELAY_CYCLES,
  parameter BIT_TIME = `BIT_CYCLES
) (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // terminal line and modem
  input wire rxd_i,
  input wire cts_i,
  output reg txd_o,
  output reg rts_o,
  output reg motor_o,
  output reg reader_run_o,
  // straps and jumpers
  input wire parity_strap_i,
  input wire full_duplex_i,
  input wire delay_disable_i,
  input wire vector_jumper_i,
  input wire offset_jumper_i,
  // interrupt requests
  output reg word_irq_o,
  output reg block_end_irq_o,
  output reg [15:0] word_vector_o,
  output reg [15:0] block_end_vector_o
);

  // receiver states, one-hot
  localparam RX_IDLE = 3'b001;
  localparam RX_SHIFT = 3'b010;
  localparam RX_STOP = 3'b100;

  reg [5:0] sync1;
  reg [5:0] sync2;
  wire rxd_s = sync2[0];
  wire cts_s = sync2[1];
  wire parity_s = sync2[2];
  wire full_duplex_s = sync2[3];
  wire delay_dis_s = sync2[4];
  wire offset_s = sync2[5];
  reg vec_sync1;
  reg vec_sync2;

  // control flags
  reg read_mode;
  reg echo_on;
  reg step_read;
  reg cont_read;
  reg word_mask;
  reg block_mask;
  reg block_pend;
  reg motor;
  reg [26:0] quiet_cnt;
  wire quiet = (quiet_cnt != 27'h0000000);

  // transmitter
  reg tx_busy;
  reg [9:0] tx_shift;
  reg [3:0] tx_bits;
  reg [20:0] tx_cnt;

  // receiver
  reg [2:0] rx_state;
  reg [7:0] rx_shift;
  reg [3:0] rx_bits;
  reg [21:0] rx_cnt;
  reg [7:0] rx_data;
  reg rx_ready;
  reg parity_err;
  reg rx_done;

  // bus request decode
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire rd = req & ~wb_we_i;
  wire wr_select = wr & (wb_adr_i == `OFS_SELECT);
  wire [2:0] sel_code = wb_dat_i[2:0];
  wire wr_tx = wr & (wb_adr_i == `OFS_TX_DATA);
  wire wr_echo = wr & (wb_adr_i == `OFS_ECHO);
  wire wr_motor = wr & (wb_adr_i == `OFS_MOTOR);
  wire wr_back = wr & (wb_adr_i == `OFS_BLOCK_ACK);
  wire rd_rx = rd & (wb_adr_i == `OFS_RX_DATA);
  wire do_init = wr_select & (sel_code == `SEL_INIT);
  wire motor_on_cmd = wr_motor & wb_dat_i[0];

  // buffer ready follows the direction the controller faces
  wire buf_ready = read_mode ? rx_ready : ~tx_busy;
  wire busy = tx_busy | (rx_state != RX_IDLE);

  // even parity across the whole character; odd count means an error
  function parity_bad;
    input [7:0] ch;
    begin
      parity_bad = ^ch;
    end
  endfunction

  // sense multiplexer; quiet forces every answer false
  function sense_bit;
    input [2:0] code;
    input hold;
    begin
      sense_bit = 1'b0;
      if (!hold) begin
        case (code)
          `SNS_READY: sense_bit = buf_ready;
          `SNS_WORD_MASK: sense_bit = word_mask;
          `SNS_NOT_BUSY: sense_bit = ~busy;
          `SNS_CTS: sense_bit = cts_s;
          `SNS_MOTOR: sense_bit = motor;
          `SNS_PARITY: sense_bit = parity_err & parity_s;
          `SNS_FULL_DUPLEX: sense_bit = full_duplex_s;
          default: sense_bit = 1'b0;
        endcase
      end
    end
  endfunction

  // two-flop synchronisers for pins and straps
  always @(posedge clk_i) begin
    if (reset_i) begin
      sync1 <= 6'h3F;
      sync2 <= 6'h3F;
      vec_sync1 <= 1'b0;
      vec_sync2 <= 1'b0;
    end else begin
      sync1 <= {offset_jumper_i, delay_disable_i, full_duplex_i,
                parity_strap_i, cts_i, rxd_i};
      sync2 <= sync1;
      vec_sync1 <= vector_jumper_i;
      vec_sync2 <= vec_sync1;
    end
  end

  // bus slave: one-cycle registered answer, unmapped reads give zero
  always @(posedge clk_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        if (wb_adr_i[7:5] == `OFS_SENSE7 >> 5 && wb_adr_i[1:0] == 2'h0)
          wb_dat_o <= {31'h00000000, sense_bit(wb_adr_i[4:2], quiet)};
        else begin
          case (wb_adr_i)
            `OFS_SENSE0_4: wb_dat_o <= {31'h00000000, ~quiet};
            `OFS_RX_DATA: wb_dat_o <= {24'h000000, rx_data};
            `OFS_STATUS: wb_dat_o <= {20'h00000, quiet, full_duplex_s,
                                      parity_err, busy, buf_ready,
                                      block_pend, block_mask, word_mask,
                                      motor, cont_read | step_read,
                                      echo_on, read_mode};
            default: wb_dat_o <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // mode, mask and motor control
  always @(posedge clk_i) begin
    if (reset_i) begin
      read_mode <= `READ_MODE_RESET;
      echo_on <= 1'b0;
      step_read <= 1'b0;
      cont_read <= 1'b0;
      word_mask <= 1'b0;
      block_mask <= 1'b0;
      block_pend <= 1'b0;
      motor <= `MOTOR_RESET;
      quiet_cnt <= 27'h0000000;
    end else begin
      if (quiet)
        quiet_cnt <= quiet_cnt - 27'h0000001;
      // step read drops the reader once a character has started
      if (step_read && rx_state == RX_SHIFT)
        step_read <= 1'b0;
      if (wr_select) begin
        case (sel_code)
          `SEL_AUTO_ECHO: begin
            read_mode <= 1'b1;
            echo_on <= 1'b1;
          end
          `SEL_KEYBOARD: read_mode <= 1'b1;
          `SEL_STEP_READ: begin
            read_mode <= 1'b1;
            step_read <= 1'b1;
          end
          `SEL_CONT_READ: begin
            read_mode <= 1'b1;
            cont_read <= 1'b1;
          end
          `SEL_INIT: begin
            read_mode <= 1'b0;
            echo_on <= 1'b0;
            step_read <= 1'b0;
            cont_read <= 1'b0;
          end
          `SEL_WORD_MASK: word_mask <= 1'b1;
          `SEL_BLOCK_MASK: begin
            block_mask <= 1'b1;
            // early block mask fires at once
            if (!word_mask)
              block_pend <= 1'b1;
          end
          `SEL_MASK_OFF: begin
            word_mask <= 1'b0;
            block_mask <= 1'b0;
            block_pend <= 1'b0;
          end
          default: read_mode <= read_mode;
        endcase
      end
      // pending clear by software; a same-cycle echo still wins
      if (wr_back)
        block_pend <= 1'b0;
      if (wr_echo && block_mask)
        block_pend <= 1'b1;
      if (wr_motor) begin
        motor <= wb_dat_i[0];
        if (motor_on_cmd) begin
          // motor on: write mode, quiet delay
          read_mode <= 1'b0;
          quiet_cnt <= delay_dis_s ? 27'h0000000 : MOTOR_DELAY[26:0];
        end
      end
    end
  end

  // transmitter: echo has priority, bus writes only in write mode
  always @(posedge clk_i) begin
    if (reset_i) begin
      tx_busy <= 1'b0;
      tx_shift <= 10'h3FF;
      tx_bits <= 4'h0;
      tx_cnt <= 21'h000000;
    end else if (do_init) begin
      tx_busy <= 1'b0;
      tx_shift <= 10'h3FF;
    end else if (!tx_busy) begin
      if (rx_done && echo_on) begin
        tx_busy <= 1'b1;
        tx_shift <= {1'b1, rx_shift, 1'b0};
        tx_bits <= 4'h0;
        tx_cnt <= BIT_TIME[20:0] - 21'h000001;
      end else if (wr_tx && !read_mode) begin
        tx_busy <= 1'b1;
        tx_shift <= {1'b1, wb_dat_i[7:0], 1'b0};
        tx_bits <= 4'h0;
        tx_cnt <= BIT_TIME[20:0] - 21'h000001;
      end
    end else if (tx_cnt != 21'h000000) begin
      tx_cnt <= tx_cnt - 21'h000001;
    end else begin
      // one bit time elapsed, move to the next bit
      tx_shift <= {1'b1, tx_shift[9:1]};
      tx_cnt <= BIT_TIME[20:0] - 21'h000001;
      if (tx_bits == 4'h9)
        tx_busy <= 1'b0;
      else
        tx_bits <= tx_bits + 4'h1;
    end
  end

  // receiver samples mid-bit; only listens in read mode (half duplex)
  always @(posedge clk_i) begin
    if (reset_i) begin
      rx_state <= RX_IDLE;
      rx_shift <= 8'h00;
      rx_bits <= 4'h0;
      rx_cnt <= 22'h000000;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (read_mode && !rxd_s) begin
            rx_state <= RX_SHIFT;
            rx_bits <= 4'h0;
            // land in the middle of the first data bit
            rx_cnt <= {1'b0, BIT_TIME[20:0]} + {2'b00, BIT_TIME[20:1]};
          end
        end
        RX_SHIFT: begin
          if (do_init)
            rx_state <= RX_IDLE;
          else if (rx_cnt != 22'h000000)
            rx_cnt <= rx_cnt - 22'h000001;
          else begin
            rx_shift <= {rxd_s, rx_shift[7:1]};
            rx_cnt <= {1'b0, BIT_TIME[20:0]} - 22'h000001;
            if (rx_bits == 4'h7)
              rx_state <= RX_STOP;
            else
              rx_bits <= rx_bits + 4'h1;
          end
        end
        RX_STOP: begin
          if (do_init)
            rx_state <= RX_IDLE;
          else if (rx_cnt != 22'h000000)
            rx_cnt <= rx_cnt - 22'h000001;
          else begin
            // a missing stop bit is not flagged; the character is kept
            rx_state <= RX_IDLE;
            rx_done <= 1'b1;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // receive buffer; a new character beats a same-cycle read clear
  always @(posedge clk_i) begin
    if (reset_i) begin
      rx_data <= 8'h00;
      rx_ready <= 1'b0;
      parity_err <= 1'b0;
    end else if (do_init) begin
      rx_ready <= 1'b0;
      parity_err <= 1'b0;
    end else if (rx_done) begin
      rx_data <= rx_shift;
      rx_ready <= 1'b1;
      parity_err <= parity_bad(rx_shift);
    end else if (rd_rx) begin
      rx_ready <= 1'b0;
    end
  end

  // pin and interrupt outputs, all registered
  always @(posedge clk_i) begin
    if (reset_i) begin
      txd_o <= 1'b1;
      rts_o <= ~`MOTOR_RESET;
      motor_o <= `MOTOR_RESET;
      reader_run_o <= 1'b0;
      word_irq_o <= 1'b0;
      block_end_irq_o <= 1'b0;
      word_vector_o <= `WORD_VECTOR;
      block_end_vector_o <= `BLOCK_VECTOR;
    end else begin
      txd_o <= tx_busy ? tx_shift[0] : 1'b1;
      rts_o <= ~motor;
      motor_o <= motor;
      reader_run_o <= cont_read | step_read;
      word_irq_o <= word_mask & buf_ready & ~quiet;
      block_end_irq_o <= block_pend & ~quiet;
      word_vector_o <= `WORD_VECTOR
                       | (vec_sync2 ? `VECTOR_RELOCATE : 16'h0000)
                       | (offset_s ? `VECTOR_OFFSET : 16'h0000);
      block_end_vector_o <= `BLOCK_VECTOR
                            | (vec_sync2 ? `VECTOR_RELOCATE : 16'h0000)
                            | (offset_s ? `VECTOR_OFFSET : 16'h0000);
    end
  end

endmodule // terminal_ctl

// [tb/terminal_ctl_sva.sv]
`timescale 1ns/1ps
`include "terminal_ctl_defs.vh"
module terminal_ctl_sva (
  // bus side
  input wire clk_i,
  input wire reset_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // line and interrupt side
  input wire txd_o,
  input wire rts_o,
  input wire motor_o,
  input wire reader_run_o,
  input wire delay_disable_i,
  input wire word_irq_o,
  input wire block_end_irq_o,
  input wire [15:0] word_vector_o,
  input wire [15:0] block_end_vector_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // request taken, and a taken write that sel[0] lets through
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr0 = take && wb_we_i && wb_sel_i[0];
  sequence sel_wr(f);
    wr0 && wb_adr_i == `OFS_SELECT && wb_dat_i[2:0] == f;
  endsequence
  sequence motor_wr;
    wr0 && wb_adr_i == `OFS_MOTOR;
  endsequence
  chk_ack_answer: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_sense_bit: assert property (take && !wb_we_i &&
    wb_adr_i >= `OFS_SENSE7 |=> wb_dat_o[31:1] == 31'h0)
    else $error("sense reply wider than one bit");
  chk_rts_follow: assert property ($rose(motor_o) |-> $fell(rts_o))
    else $error("rts not inverse of motor");
  chk_reset_motor: assert property ($fell(reset_i) |-> motor_o && !rts_o)
    else $error("motor not on after reset");
  chk_word_vec: assert property ((word_vector_o & ~16'h0120) == 16'h0002)
    else $error("word vector wrong");
  chk_block_vec: assert property ((block_end_vector_o & ~16'h0120) == 16'h0006)
    else $error("block-end vector wrong");
  chk_init_mark: assert property (sel_wr(`SEL_INIT) |=>
    ##1 (txd_o && !reader_run_o)[*2])
    else $error("line not marking after init");
  chk_mask_off: assert property (sel_wr(`SEL_MASK_OFF) |->
    ##2 (!word_irq_o && !block_end_irq_o)[*2])
    else $error("interrupt after masks cleared");
  chk_motor_set: assert property (motor_wr |=> ##1
    motor_o == $past(wb_dat_i[0], 2))
    else $error("motor not following write");
  chk_motor_quiet: assert property (motor_wr ##0 wb_dat_i[0] &&
    !delay_disable_i |-> ##2 (!word_irq_o && !block_end_irq_o)[*8])
    else $error("interrupt during motor delay");
endmodule // terminal_ctl_sva

bind terminal_ctl terminal_ctl_sva i_terminal_ctl_sva (.clk_i(clk_i),
  .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .txd_o(txd_o), .rts_o(rts_o), .motor_o(motor_o),
  .reader_run_o(reader_run_o), .delay_disable_i(delay_disable_i),
  .word_irq_o(word_irq_o), .block_end_irq_o(block_end_irq_o),
  .word_vector_o(word_vector_o), .block_end_vector_o(block_end_vector_o));

// [tb/terminal_model.sv]
`timescale 1ns/1ps
module terminal_model #(
  parameter BIT_TIME = 16
) (
  // clock
  input wire clk_i,
  // line to and from the controller
  input wire txd_i,
  output reg rxd_o,
  output reg cts_o
);
  reg [7:0] got;
  integer got_cnt;
  // line idles marking, modem not ready
  initial begin
    rxd_o = 1'h1;
    cts_o = 1'h0;
    got_cnt = 0;
  end
  // printer side: sample mid-bit, stop bit is not checked
  always begin : rx
    integer i;
    @(negedge txd_i);
    repeat (BIT_TIME + BIT_TIME / 2) @(posedge clk_i);
    for (i = 0; i < 8; i = i + 1) begin
      got[i] = txd_i;
      repeat (BIT_TIME) @(posedge clk_i);
    end
    got_cnt = got_cnt + 1;
  end
  // keyboard side: start, eight bits lsb first, stop
  task send(input [7:0] c);
    integer i;
    begin
      for (i = 0; i < 10; i = i + 1) begin
        rxd_o <= (i == 0) ? 1'h0 : (i == 9) ? 1'h1 : c[i - 1];
        repeat (BIT_TIME) @(posedge clk_i);
      end
    end
  endtask
endmodule // terminal_model

// [tb/tb_terminal_ctl.sv]
`timescale 1ns/1ps
`include "terminal_ctl_defs.vh"
module tb_terminal_ctl;
  localparam BT = 16;
  reg clk_i = 1'h0;
  reg reset_i = 1'h1;
  reg wb_cyc_i = 1'h0;
  reg wb_stb_i = 1'h0;
  reg wb_we_i = 1'h0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'h0;
  reg [31:0] wb_dat_i = 32'h0;
  reg full_duplex_i = 1'h0;
  reg vector_jumper_i = 1'h0;
  reg offset_jumper_i = 1'h0;
  reg parity_strap_i = 1'h0;
  reg delay_disable_i = 1'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, rxd_i, cts_i, txd_o, rts_o, motor_o, reader_run_o;
  wire word_irq_o, block_end_irq_o;
  wire [15:0] word_vector_o, block_end_vector_o;
  integer errors = 0;
  integer compares = 0;
  integer cycles = 0;
  integer n;
  reg [31:0] q;

  always #2.5 clk_i = ~clk_i;

  // short motor delay and bit time keep the run brief
  terminal_ctl #(.MOTOR_DELAY(50), .BIT_TIME(BT)) i_terminal_ctl (
    .clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rxd_i(rxd_i), .cts_i(cts_i), .txd_o(txd_o),
    .rts_o(rts_o), .motor_o(motor_o), .reader_run_o(reader_run_o),
    .parity_strap_i(parity_strap_i), .full_duplex_i(full_duplex_i),
    .delay_disable_i(delay_disable_i),
    .vector_jumper_i(vector_jumper_i),
    .offset_jumper_i(offset_jumper_i), .word_irq_o(word_irq_o),
    .block_end_irq_o(block_end_irq_o), .word_vector_o(word_vector_o),
    .block_end_vector_o(block_end_vector_o));
  terminal_model #(.BIT_TIME(BT)) i_terminal_model (.clk_i(clk_i),
    .txd_i(txd_o), .rxd_o(rxd_i), .cts_o(cts_i));

  task test_done;
    begin
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // one classic cycle; request held until ack is sampled
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      n = 0;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'h1 && n < 50) begin
        n = n + 1;
        @(posedge clk_i);
      end
      chk("ackwait", 0, n == 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge clk_i);
    end
  endtask

  task sns(input [2:0] f, input e);
    begin
      bus(1'h0, `OFS_SENSE7 + {3'h0, f, 2'h0}, 32'h0);
      chk("sense", {31'h0, e}, q);
    end
  endtask

  // bounded wait for the terminal to print k characters
  task got_wait(input integer k);
    begin
      n = 0;
      while (i_terminal_model.got_cnt < k && n < 500) begin
        n = n + 1;
        @(posedge clk_i);
      end
      chk("printed", k, i_terminal_model.got_cnt);
    end
  endtask

  task t_reset;
    begin
      chk("motor", 1, motor_o);
      chk("rts", 0, rts_o);
      chk("txd", 1, txd_o);
      chk("wvec", 32'h0002, word_vector_o);
      chk("bvec", 32'h0006, block_end_vector_o);
      bus(1'h0, `OFS_SENSE0_4, 32'h0);
      chk("fitted", 1, q);
      sns(`SNS_CTS, 1'h0);
      sns(`SNS_FULL_DUPLEX, 1'h0);
      i_terminal_model.cts_o <= 1'h1;
      full_duplex_i <= 1'h1;
      vector_jumper_i <= 1'h1;
      offset_jumper_i <= 1'h1;
      repeat (4) @(posedge clk_i);
      sns(`SNS_CTS, 1'h1);
      sns(`SNS_FULL_DUPLEX, 1'h1);
      chk("wvec", 32'h0122, word_vector_o);
      chk("bvec", 32'h0126, block_end_vector_o);
      full_duplex_i <= 1'h0;
      vector_jumper_i <= 1'h0;
      offset_jumper_i <= 1'h0;
      repeat (4) @(posedge clk_i);
      bus(1'h0, 8'h30, 32'h0);
      chk("unmapped", 0, q);
    end
  endtask

  task t_tx;
    begin
      bus(1'h1, `OFS_SELECT, `SEL_INIT);
      bus(1'h1, `OFS_TX_DATA, 32'hA5);
      sns(`SNS_NOT_BUSY, 1'h0);
      sns(`SNS_READY, 1'h0);
      got_wait(1);
      chk("txchar", 32'hA5, i_terminal_model.got);
      repeat (BT) @(posedge clk_i);
      sns(`SNS_NOT_BUSY, 1'h1);
      sns(`SNS_READY, 1'h1);
    end
  endtask

  task t_irq;
    begin
      bus(1'h1, `OFS_SELECT, `SEL_WORD_MASK);
      sns(`SNS_WORD_MASK, 1'h1);
      chk("wirq", 1, word_irq_o);
      bus(1'h1, `OFS_SELECT, `SEL_BLOCK_MASK);
      chk("birq", 0, block_end_irq_o);
      bus(1'h1, `OFS_ECHO, 32'h0);
      chk("birq", 1, block_end_irq_o);
      bus(1'h1, `OFS_BLOCK_ACK, 32'h0);
      chk("birq", 0, block_end_irq_o);
      bus(1'h1, `OFS_SELECT, `SEL_MASK_OFF);
      chk("wirq", 0, word_irq_o);
      sns(`SNS_WORD_MASK, 1'h0);
      // block-end mask without word mask raises the request at once
      bus(1'h1, `OFS_SELECT, `SEL_BLOCK_MASK);
      chk("birq", 1, block_end_irq_o);
      bus(1'h1, `OFS_SELECT, `SEL_MASK_OFF);
      chk("birq", 0, block_end_irq_o);
    end
  endtask

  task t_read;
    begin
      parity_strap_i <= 1'h1;
      bus(1'h1, `OFS_SELECT, `SEL_AUTO_ECHO);
      i_terminal_model.send(8'h3C);
      got_wait(2);
      chk("echo", 32'h3C, i_terminal_model.got);
      sns(`SNS_READY, 1'h1);
      bus(1'h0, `OFS_RX_DATA, 32'h0);
      chk("rxchar", 32'h3C, q);
      sns(`SNS_READY, 1'h0);
      bus(1'h1, `OFS_SELECT, `SEL_INIT);
      bus(1'h1, `OFS_SELECT, `SEL_STEP_READ);
      chk("reader", 1, reader_run_o);
      i_terminal_model.send(8'h5A);
      chk("reader", 0, reader_run_o);
      bus(1'h1, `OFS_SELECT, `SEL_CONT_READ);
      i_terminal_model.send(8'h11);
      chk("reader", 1, reader_run_o);
      bus(1'h1, `OFS_SELECT, `SEL_INIT);
      chk("reader", 0, reader_run_o);
      bus(1'h1, `OFS_SELECT, `SEL_KEYBOARD);
      i_terminal_model.send(8'hC3);
      repeat (4) @(posedge clk_i);
      bus(1'h0, `OFS_RX_DATA, 32'h0);
      chk("rxchar", 32'hC3, q);
      sns(`SNS_PARITY, 1'h0);
      // a single one bit breaks even parity
      i_terminal_model.send(8'h01);
      repeat (4) @(posedge clk_i);
      sns(`SNS_PARITY, 1'h1);
      parity_strap_i <= 1'h0;
      repeat (4) @(posedge clk_i);
      sns(`SNS_PARITY, 1'h0);
      chk("printed", 2, i_terminal_model.got_cnt);
    end
  endtask

  task t_motor;
    begin
      bus(1'h1, `OFS_MOTOR, 32'h0);
      chk("motor", 0, motor_o);
      chk("rts", 1, rts_o);
      sns(`SNS_MOTOR, 1'h0);
      bus(1'h1, `OFS_MOTOR, 32'h1);
      bus(1'h0, `OFS_SENSE0_4, 32'h0);
      chk("quiet", 0, q);
      repeat (60) @(posedge clk_i);
      sns(`SNS_MOTOR, 1'h1);
      bus(1'h0, `OFS_SENSE0_4, 32'h0);
      chk("fitted", 1, q);
      // with the delay strapped off, motor-on leaves senses live
      delay_disable_i <= 1'h1;
      repeat (4) @(posedge clk_i);
      bus(1'h1, `OFS_MOTOR, 32'h1);
      bus(1'h0, `OFS_SENSE0_4, 32'h0);
      chk("nodelay", 1, q);
      delay_disable_i <= 1'h0;
    end
  endtask

  // hang guard well above the expected run of about 1300 cycles
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      test_done;
    end
  end

  // reset, let the strap synchronisers settle, then the scenarios
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    t_reset;
    t_tx;
    t_irq;
    t_read;
    t_motor;
    test_done;
  end
endmodule // tb_terminal_ctl
